/* File: src/nirq_defs.vh */
`ifndef NIRQ_DEFS_VH
`define NIRQ_DEFS_VH

// Register offsets
`define NIRQ_OFF_MASK_TF 8'h17
`define NIRQ_OFF_MASK_EW 8'h18
`define NIRQ_OFF_MASK_TR 8'h19
`define NIRQ_OFF_MAIN 8'h1a
`define NIRQ_OFF_TF 8'h1b
`define NIRQ_OFF_EW 8'h1c
`define NIRQ_OFF_TR 8'h1d

// Reset values
`define NIRQ_MASK_RST 8'h00
`define NIRQ_STAT_RST 8'h00

// Timer/field status bits
`define NIRQ_TF_CMD_DONE 7
`define NIRQ_TF_NRT 6
`define NIRQ_TF_GPT 5
`define NIRQ_TF_FIELD_ON 4
`define NIRQ_TF_FIELD_OFF 3
`define NIRQ_TF_CA_COLL 2
`define NIRQ_TF_CA_GUARD 1
`define NIRQ_TF_RATE 0

// Error/wake-up status bits
`define NIRQ_EW_CRC 7
`define NIRQ_EW_PAR 6
`define NIRQ_EW_SOFT 5
`define NIRQ_EW_HARD 4
`define NIRQ_EW_WTO 3
`define NIRQ_EW_AMP 2
`define NIRQ_EW_PHASE 1
`define NIRQ_EW_CAP 0

// Target responder status bits
`define NIRQ_TR_FON_WAIT 7
`define NIRQ_TR_SLOT_LOW 6
`define NIRQ_TR_P2P_ON 5
`define NIRQ_TR_AUTO_RSP 4
`define NIRQ_TR_FRATE 3
`define NIRQ_TR_RSVD 2
`define NIRQ_TR_ACT_STAR 1
`define NIRQ_TR_ACT 0

// Reserved bit of the target responder status never sets
`define NIRQ_TR_IMPL 8'hfb

`endif

/* File: src/nirq_status_regs.v */
// Contract
// - Timer/field and target status registers return flags on read, then clear.
// - Error/wake-up register clears after the main interrupt register is read.
// - Timer/field bits 7,6,5: command done, no-response timer, general timer.
// - Bit 4 external field rises above level; bit 3 falls below.
// - Timer/field bit 2 sets on collision during collision avoidance.
// - Bit 1 sets after guard time when own field switched on.
// - Timer/field bit 0 sets when target mode recognises initiator bit rate.
// - Error bit 5 sets on soft framing error.
// - Error bit 4 sets on hard framing error.
// - Error bit 3 sets per wake-up timeout when every-timeout option selected.
// - Error bits 2,1,0: amplitude, phase, capacitance delta over reference.
// - Target bit 7 sets on second field-on wait timer interrupt.
// - Target bit 6 sets when four unused slot numbers remain.
// - Target bit 5 sets after clean collision avoidance and field turned on.
// - Target bit 4 sets on automatic anticollision or polling response.
// - Target bit 3 sets after automatic polling response at 212/424 kb/s.
// - Target bit 1 sets when the starred active state is reached.
// - Target bit 0 sets when the plain active state is reached.
// - A mask bit of one keeps its status bit from raising the request.
`timescale 1ns/1ps
`default_nettype none
`include "nirq_defs.vh"

module nirq_status_regs #(
    parameter WIDTH = 8
) (
    input wire MCLK,
    input wire RST,
    input wire [7:0] ADDR,
    input wire [WIDTH-1:0] WDATA,
    input wire WR,
    input wire RD,
    output reg [WIDTH-1:0] RDATA,
    input wire CMD_DONE,
    input wire NRT_EXPIRE,
    input wire GPT_EXPIRE,
    input wire FIELD_ON,
    input wire FIELD_OFF,
    input wire CA_COLLISION,
    input wire CA_GUARD_DONE,
    input wire RATE_FOUND,
    input wire CRC_ERR,
    input wire PARITY_ERR,
    input wire SOFT_FRAME_ERR,
    input wire HARD_FRAME_ERR,
    input wire WAKEUP_TIMEOUT,
    input wire WAKEUP_EVERY_TIMEOUT,
    input wire AMP_OVER_REF,
    input wire PHASE_OVER_REF,
    input wire CAP_OVER_REF,
    input wire FIELD_ON_WAIT_TIMER,
    input wire SLOT_NUMBER_LOW,
    input wire P2P_FIELD_ON,
    input wire AUTO_RESPONSE_SENT,
    input wire FRATE_RESPONSE_SENT,
    input wire STARRED_ACTIVE,
    input wire PLAIN_ACTIVE,
    output reg IRQ
);

    // Latched flags
    reg [WIDTH-1:0] tf_q;
    reg [WIDTH-1:0] ew_q;
    reg [WIDTH-1:0] tr_q;
    wire [WIDTH-1:0] tf_d;
    wire [WIDTH-1:0] ew_d;
    wire [WIDTH-1:0] tr_d;

    // Mask registers
    reg [WIDTH-1:0] mask_tf_q;
    reg [WIDTH-1:0] mask_ew_q;
    reg [WIDTH-1:0] mask_tr_q;
    wire [WIDTH-1:0] mask_tf_d;
    wire [WIDTH-1:0] mask_ew_d;
    wire [WIDTH-1:0] mask_tr_d;

    // Events, pending flags and the request
    wire [WIDTH-1:0] tf_ev;
    wire [WIDTH-1:0] ew_ev;
    wire [WIDTH-1:0] tr_ev;
    wire [WIDTH-1:0] tr_impl;
    wire [WIDTH-1:0] tf_pend;
    wire [WIDTH-1:0] ew_pend;
    wire [WIDTH-1:0] tr_pend;
    wire tf_any;
    wire ew_any;
    wire tr_any;
    reg irq_d;

    // Register port decode
    reg [WIDTH-1:0] rdata_d;
    wire rd_tf;
    wire rd_ew_clr;
    wire rd_tr;
    wire wr_mask_tf;
    wire wr_mask_ew;
    wire wr_mask_tr;

    assign tf_ev[`NIRQ_TF_CMD_DONE] = CMD_DONE;
    assign tf_ev[`NIRQ_TF_NRT] = NRT_EXPIRE;
    assign tf_ev[`NIRQ_TF_GPT] = GPT_EXPIRE;
    assign tf_ev[`NIRQ_TF_FIELD_ON] = FIELD_ON;
    assign tf_ev[`NIRQ_TF_FIELD_OFF] = FIELD_OFF;
    assign tf_ev[`NIRQ_TF_CA_COLL] = CA_COLLISION;
    assign tf_ev[`NIRQ_TF_CA_GUARD] = CA_GUARD_DONE;
    assign tf_ev[`NIRQ_TF_RATE] = RATE_FOUND;

    assign ew_ev[`NIRQ_EW_CRC] = CRC_ERR;
    assign ew_ev[`NIRQ_EW_PAR] = PARITY_ERR;
    assign ew_ev[`NIRQ_EW_SOFT] = SOFT_FRAME_ERR;
    assign ew_ev[`NIRQ_EW_HARD] = HARD_FRAME_ERR;
    // Only the every-timeout option reports each timeout
    assign ew_ev[`NIRQ_EW_WTO] = WAKEUP_TIMEOUT & WAKEUP_EVERY_TIMEOUT;
    assign ew_ev[`NIRQ_EW_AMP] = AMP_OVER_REF;
    assign ew_ev[`NIRQ_EW_PHASE] = PHASE_OVER_REF;
    assign ew_ev[`NIRQ_EW_CAP] = CAP_OVER_REF;

    assign tr_ev[`NIRQ_TR_FON_WAIT] = FIELD_ON_WAIT_TIMER;
    assign tr_ev[`NIRQ_TR_SLOT_LOW] = SLOT_NUMBER_LOW;
    assign tr_ev[`NIRQ_TR_P2P_ON] = P2P_FIELD_ON;
    assign tr_ev[`NIRQ_TR_AUTO_RSP] = AUTO_RESPONSE_SENT;
    assign tr_ev[`NIRQ_TR_FRATE] = FRATE_RESPONSE_SENT;
    assign tr_ev[`NIRQ_TR_RSVD] = 1'b0;
    assign tr_ev[`NIRQ_TR_ACT_STAR] = STARRED_ACTIVE;
    assign tr_ev[`NIRQ_TR_ACT] = PLAIN_ACTIVE;

    assign rd_tf = RD && (ADDR == `NIRQ_OFF_TF);
    assign rd_tr = RD && (ADDR == `NIRQ_OFF_TR);
    // Main register lives elsewhere; its read address still clears this one
    assign rd_ew_clr = RD && (ADDR == `NIRQ_OFF_MAIN);

    assign wr_mask_tf = WR && (ADDR == `NIRQ_OFF_MASK_TF);
    assign wr_mask_ew = WR && (ADDR == `NIRQ_OFF_MASK_EW);
    assign wr_mask_tr = WR && (ADDR == `NIRQ_OFF_MASK_TR);
    // Reserved target bit is tied off in both the flag and its mask
    assign tr_impl = `NIRQ_TR_IMPL;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            reg tf_nx;
            reg ew_nx;
            reg tr_nx;
            reg mtf_nx;
            reg mew_nx;
            reg mtr_nx;
            reg tf_pn;
            reg ew_pn;
            reg tr_pn;

            // Set beats clear: an event in the clearing read cycle stays latched
            always @* begin
                tf_nx = tf_q[i];
                if (rd_tf) begin
                    tf_nx = 1'b0;
                end
                if (tf_ev[i]) begin
                    tf_nx = 1'b1;
                end
            end

            always @* begin
                ew_nx = ew_q[i];
                if (rd_ew_clr) begin
                    ew_nx = 1'b0;
                end
                if (ew_ev[i]) begin
                    ew_nx = 1'b1;
                end
            end

            always @* begin
                tr_nx = tr_q[i];
                if (rd_tr) begin
                    tr_nx = 1'b0;
                end
                if (tr_ev[i]) begin
                    tr_nx = 1'b1;
                end
                // Reserved bit never latches
                if (!tr_impl[i]) begin
                    tr_nx = 1'b0;
                end
            end

            always @* begin
                mtf_nx = mask_tf_q[i];
                if (wr_mask_tf) begin
                    mtf_nx = WDATA[i];
                end
            end

            always @* begin
                mew_nx = mask_ew_q[i];
                if (wr_mask_ew) begin
                    mew_nx = WDATA[i];
                end
            end

            always @* begin
                mtr_nx = mask_tr_q[i];
                if (wr_mask_tr) begin
                    mtr_nx = WDATA[i] & tr_impl[i];
                end
            end

            // Masked flags are still latched; only the request is held back
            always @* begin
                tf_pn = tf_d[i] & ~mask_tf_q[i];
                ew_pn = ew_d[i] & ~mask_ew_q[i];
                tr_pn = tr_d[i] & ~mask_tr_q[i];
            end

            assign tf_d[i] = tf_nx;
            assign ew_d[i] = ew_nx;
            assign tr_d[i] = tr_nx;
            assign mask_tf_d[i] = mtf_nx;
            assign mask_ew_d[i] = mew_nx;
            assign mask_tr_d[i] = mtr_nx;
            assign tf_pend[i] = tf_pn;
            assign ew_pend[i] = ew_pn;
            assign tr_pend[i] = tr_pn;
        end
    endgenerate

    // Idle and unmapped reads return zero so no stale value lingers on the bus
    always @* begin
        rdata_d = {WIDTH{1'b0}};
        if (RD) begin
            case (ADDR)
                `NIRQ_OFF_MASK_TF: begin
                    rdata_d = mask_tf_q;
                end
                `NIRQ_OFF_MASK_EW: begin
                    rdata_d = mask_ew_q;
                end
                `NIRQ_OFF_MASK_TR: begin
                    rdata_d = mask_tr_q;
                end
                `NIRQ_OFF_TF: begin
                    rdata_d = tf_q;
                end
                `NIRQ_OFF_EW: begin
                    rdata_d = ew_q;
                end
                `NIRQ_OFF_TR: begin
                    rdata_d = tr_q;
                end
                default: begin
                    // Main register address lands here and reads zero
                    rdata_d = {WIDTH{1'b0}};
                end
            endcase
        end
    end

    assign tf_any = |tf_pend;
    assign ew_any = |ew_pend;
    assign tr_any = |tr_pend;

    // Computed from next state so the request drops together with the clear
    always @* begin
        irq_d = 1'b0;
        if (tf_any) begin
            irq_d = 1'b1;
        end
        if (ew_any) begin
            irq_d = 1'b1;
        end
        if (tr_any) begin
            irq_d = 1'b1;
        end
    end

    // Flag and mask registers
    always @(posedge MCLK) begin
        if (RST) begin
            tf_q <= `NIRQ_STAT_RST;
        end else begin
            tf_q <= tf_d;
        end
    end

    always @(posedge MCLK) begin
        if (RST) begin
            ew_q <= `NIRQ_STAT_RST;
        end else begin
            ew_q <= ew_d;
        end
    end

    always @(posedge MCLK) begin
        if (RST) begin
            tr_q <= `NIRQ_STAT_RST;
        end else begin
            tr_q <= tr_d;
        end
    end

    always @(posedge MCLK) begin
        if (RST) begin
            mask_tf_q <= `NIRQ_MASK_RST;
        end else begin
            mask_tf_q <= mask_tf_d;
        end
    end

    always @(posedge MCLK) begin
        if (RST) begin
            mask_ew_q <= `NIRQ_MASK_RST;
        end else begin
            mask_ew_q <= mask_ew_d;
        end
    end

    always @(posedge MCLK) begin
        if (RST) begin
            mask_tr_q <= `NIRQ_MASK_RST;
        end else begin
            mask_tr_q <= mask_tr_d;
        end
    end

    // Outputs come straight from flops
    always @(posedge MCLK) begin
        if (RST) begin
            RDATA <= {WIDTH{1'b0}};
        end else begin
            RDATA <= rdata_d;
        end
    end

    always @(posedge MCLK) begin
        if (RST) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= irq_d;
        end
    end

endmodule // nirq_status_regs
`default_nettype wire

/* File: dv/nirq_status_regs_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module nirq_asserts #(parameter WIDTH = 8) (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic [7:0] ADDR,
    input wire logic [WIDTH-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [WIDTH-1:0] RDATA,
    input wire logic IRQ,
    input wire logic CMD_DONE,
    input wire logic CRC_ERR,
    input wire logic WAKEUP_TIMEOUT,
    input wire logic WAKEUP_EVERY_TIMEOUT,
    input wire logic PLAIN_ACTIVE
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (RST);
    wire rd_tf = RD && ADDR == 8'h1b;
    wire rd_ew = RD && ADDR == 8'h1c;
    logic m7_q;
    // Shadow of one mask bit only, to keep the checker small
    always @(posedge MCLK) m7_q <= RST ? 1'b0 : (WR && ADDR == 8'h18) ? WDATA[7] : m7_q;
    rd_idle_a: assert property (!$past(RD) |-> RDATA == 8'h00) else $error("read data not idle");
    tf_clear_a: assert property (rd_tf && !CMD_DONE ##1 rd_tf && !CMD_DONE |=> !RDATA[7]) else $error("tf kept");
    ew_clear_a: assert property (RD && ADDR == 8'h1a && !CRC_ERR ##1 rd_ew |=> !RDATA[7]) else $error("ew kept");
    done_set_a: assert property (CMD_DONE ##1 rd_tf |=> RDATA[7]) else $error("done lost");
    crc_set_a: assert property (CRC_ERR ##1 rd_ew |=> RDATA[7]) else $error("crc lost");
    wto_set_a: assert property (WAKEUP_TIMEOUT && WAKEUP_EVERY_TIMEOUT ##1 rd_ew |=> RDATA[3]) else $error("wto lost");
    act_set_a: assert property (PLAIN_ACTIVE ##1 RD && ADDR == 8'h1d |=> RDATA[0]) else $error("act lost");
    irq_raise_a: assert property (CRC_ERR && !m7_q |=> IRQ) else $error("no request");
    cover property (rd_tf ##1 rd_tf);
    cover property (IRQ ##1 !IRQ);
    cover property (WR && ADDR == 8'h18);
endmodule // nirq_asserts
bind nirq_status_regs nirq_asserts #(.WIDTH(WIDTH)) u_chk (.MCLK, .RST, .ADDR, .WDATA, .WR, .RD, .RDATA, .IRQ,
    .CMD_DONE, .CRC_ERR, .WAKEUP_TIMEOUT, .WAKEUP_EVERY_TIMEOUT, .PLAIN_ACTIVE);
`default_nettype wire

/* File: dv/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic MCLK = 1'b0, RST = 1'b1, WR = 1'b0, RD = 1'b0, wte = 1'b0, IRQ;
    logic [7:0] ADDR = 8'h00, WDATA = 8'h00, tf = 8'h00, ew = 8'h00, tr = 8'h00, RDATA;
    int num_errors = 0, checks = 0, cyc = 0;
    always #4 MCLK = ~MCLK;
    nirq_status_regs dut (.MCLK, .RST, .ADDR, .WDATA, .WR, .RD, .RDATA, .IRQ, .CMD_DONE(tf[7]), .NRT_EXPIRE(tf[6]),
        .GPT_EXPIRE(tf[5]), .FIELD_ON(tf[4]), .FIELD_OFF(tf[3]), .CA_COLLISION(tf[2]), .CA_GUARD_DONE(tf[1]),
        .RATE_FOUND(tf[0]), .CRC_ERR(ew[7]), .PARITY_ERR(ew[6]), .SOFT_FRAME_ERR(ew[5]), .HARD_FRAME_ERR(ew[4]),
        .WAKEUP_TIMEOUT(ew[3]), .WAKEUP_EVERY_TIMEOUT(wte), .AMP_OVER_REF(ew[2]), .PHASE_OVER_REF(ew[1]),
        .CAP_OVER_REF(ew[0]), .FIELD_ON_WAIT_TIMER(tr[7]), .SLOT_NUMBER_LOW(tr[6]), .P2P_FIELD_ON(tr[5]),
        .AUTO_RESPONSE_SENT(tr[4]), .FRATE_RESPONSE_SENT(tr[3]), .STARRED_ACTIVE(tr[1]), .PLAIN_ACTIVE(tr[0]));
    task conclude;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge MCLK) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            num_errors++;
            conclude;
        end
    end
    task chk(input logic [7:0] got, exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task fire(input int r, input logic [7:0] v);
        @(posedge MCLK);
        if (r == 0) tf <= v;
        else if (r == 1) ew <= v;
        else tr <= v;
    endtask
    task wr(input logic [7:0] a, d);
        @(posedge MCLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge MCLK);
        WR <= 1'b0;
    endtask
    // Two reads back to back; the request is seen only in the cycle between event and clearing read
    task rd(input logic [7:0] a, b, ea, eb, input logic ei);
        @(posedge MCLK);
        {tf, ew, tr} <= 24'h000000;
        ADDR <= a;
        RD <= 1'b1;
        #1 chk({7'h00, IRQ}, {7'h00, ei});
        @(posedge MCLK);
        ADDR <= b;
        #1 chk(RDATA, ea);
        @(posedge MCLK);
        RD <= 1'b0;
        #1 chk(RDATA, eb);
        chk({7'h00, IRQ}, 8'h00);
    endtask
    task t_reg(input int r, input logic [7:0] a, b, keep, ma);
        logic [7:0] v;
        for (int i = 0; i < 8; i++) begin
            v = 8'h01 << i;
            fire(r, v);
            rd(a, b, v & keep, 8'h00, |(v & keep));
        end
        wr(ma, 8'hff);
        fire(r, 8'hff);
        rd(a, b, keep, 8'h00, 1'b0);
        rd(ma, 8'h30, (ma == 8'h19) ? 8'hfb : 8'hff, 8'h00, 1'b0);
        wr(ma, 8'h00);
        $display("register %h done", a);
    endtask
    initial begin
        repeat (8) @(posedge MCLK);
        RST <= 1'b0;
        wte <= 1'b1;
        t_reg(0, 8'h1b, 8'h1b, 8'hff, 8'h17);
        t_reg(1, 8'h1c, 8'h1a, 8'hff, 8'h18);
        t_reg(2, 8'h1d, 8'h1d, 8'hfb, 8'h19);
        fire(1, 8'h80);
        rd(8'h1a, 8'h1c, 8'h00, 8'h00, 1'b1);
        $display("main read clear done");
        @(posedge MCLK) wte <= 1'b0;
        t_reg(1, 8'h1c, 8'h1a, 8'hf7, 8'h18);
        conclude;
    end
endmodule // testbench
`default_nettype wire
